/* bench/gpp_board.sv */
// Board model: switches, pull-ups and LEDs on every pin lane.
// Assumes one lane per pin; switches are set by the bench.
`timescale 1ns/1ps
`default_nettype none

module gpp_board #(
    parameter int NL = 104
) (
    // Clock
    input wire logic sys_clk,
    // Device side
    input wire logic [NL-1:0] pinOut,
    input wire logic [NL-1:0] pinOe,
    input wire logic [NL-1:0] pullUpEn,
    // Switches
    input wire logic [NL-1:0] swEn,
    input wire logic [NL-1:0] swVal,
    output logic [NL-1:0] pinIn
);
    logic [NL-1:0] float_q = '0;
    // Undriven lanes toggle so a stale level never passes
    always @(posedge sys_clk) begin
        float_q <= ~float_q;
    end
    // Driven lane wins; an open-drain lane at 0 sinks the LED current
    // An input lane with pull-up and its switch off reads high
    assign pinIn = (pinOe & pinOut) | (~pinOe & swEn & swVal)
        | (~pinOe & ~swEn & (pullUpEn | float_q));
endmodule // gpp_board
`default_nettype wire

/* bench/gpp_top_monitor.sv */
// Checker for the port bank: pin drive, pull-up and interrupt relations.
// Sees only the top ports; attached to every gpp_top instance by bind.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.vh"

module gpp_top_monitor (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Observed ports
    input wire s_axi_bvalid,
    input wire [8*`GPP_NPORTS-1:0] pinIn,
    input wire [8*`GPP_NPORTS-1:0] pinOut,
    input wire [8*`GPP_NPORTS-1:0] pinOe,
    input wire [8*`GPP_NPORTS-1:0] pullUpEn,
    input wire [7:0] analogInputSel,
    input wire irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence resetExit;
        $rose(rst_n);
    endsequence
    sequence keyFall;
        |($past(pinIn[39:32]) & ~pinIn[39:32]);
    endsequence

    a_port4_byte_dir: assert property (pinOe[39:32] == 8'h00 || pinOe[39:32] == 8'hff)
        else $error("port 4 direction split between pins");
    a_input_only_pins: assert property (!pinOe[0] && !pinOe[7])
        else $error("input-only pin driven");
    a_pull_input_only: assert property ((pullUpEn & pinOe) == '0)
        else $error("pull-up on a driven pin");
    a_analog_pull_off: assert property (
        (analogInputSel & $past(analogInputSel) & pullUpEn[15:8]) == 8'h00)
        else $error("pull-up on analog pin");
    a_open_drain_sink: assert property ((pinOut[51:48] | pinOut[75:72]) == 4'h0)
        else $error("open-drain pin drives high");
    a_reset_all_inputs: assert property (
        resetExit |-> (pinOe == '0 && pullUpEn == '0 && !irq) [*2])
        else $error("pin not input after reset");
    a_irq_clear_write: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without a write");
    // Mask is not visible here, so the set path is only covered
    c_key_fall_irq: cover property (keyFall ##3 irq);
endmodule // gpp_top_monitor

bind gpp_top gpp_top_monitor u_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_bvalid(s_axi_bvalid), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .analogInputSel(analogInputSel), .irq(irq));
`default_nettype wire

/* bench/tb_general_purpose_port_pins.sv */
// Testbench for the port bank: register access over AXI4-Lite, pin checks.
// Assumes gpp_top and the board model; checker is attached by bind.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.vh"

module tb_general_purpose_port_pins;
    localparam int NL = 8*`GPP_NPORTS;
    logic sys_clk, rst_n, irq, feedbackResistorCut;
    logic [`GPP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NL-1:0] pinIn, pinOut, pinOe, pullUpEn, swEn, swVal;
    logic [7:0] analogInputSel;
    int errorCnt = 0;
    int checks = 0;
    int cycles = 0;

    gpp_top dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut,
        .pinOe, .pullUpEn, .analogInputSel, .feedbackResistorCut, .irq);
    gpp_board #(.NL(NL)) board (.sys_clk, .pinOut, .pinOe, .pullUpEn, .swEn, .swVal, .pinIn);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Address and data go out together; each is dropped once taken
    task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic awDone, wDone;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awDone = 1'b0;
        wDone = 1'b0;
        while (!(awDone && wDone)) begin
            @(posedge sys_clk);
            if (!awDone && s_axi_awready) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        chk(s_axi_bresp, er, "write response");
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                       input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata & m, exp, "read data");
        chk(s_axi_rresp, er, "read response");
        s_axi_rready <= 1'b0;
    endtask

    // Tests take under two hundred cycles; a hang stops here
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errorCnt++;
            $display("wrong value at %0t: timeout", $time);
            printVerdict;
        end
    end

    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        swEn = '0;
        swEn[39:32] = 8'hff;
        swVal = '1;
        analogInputSel = 8'h00;
        feedbackResistorCut = 1'b1;
        idle(8);
        rst_n <= 1'b1;
        idle(2);
        chk(|{pinOe, pullUpEn, irq}, 0, "reset drive");
        axr(12'h024, 32'hffffffff, 32'hff, `GPP_RESP_OKAY);
        axr(12'h028, 32'hffffffff, 32'h00, `GPP_RESP_OKAY);
        $display("test 1 finished");
        axw(12'h024, 8'h5a, `GPP_RESP_OKAY);
        axw(12'h020, 8'h0f, `GPP_RESP_OKAY);
        axw(12'h028, 8'hff, `GPP_RESP_OKAY);
        idle(3);
        chk(pinOe[23:16], 8'ha5, "port 2 direction");
        chk(pinOut[23:16] & 8'ha5, 8'h05, "port 2 drive");
        chk(pullUpEn[23:16], 8'h5a, "port 2 pull-up");
        axr(12'h02c, 32'hffffffff, 32'h5f, `GPP_RESP_OKAY);
        $display("test 2 finished");
        axw(12'h044, 8'hfe, `GPP_RESP_OKAY);
        idle(3);
        chk(pinOe[39:32], 8'hff, "port 4 all out");
        axw(12'h044, 8'h01, `GPP_RESP_OKAY);
        idle(3);
        chk(pinOe[39:32], 8'h00, "port 4 all in");
        $display("test 3 finished");
        axw(12'h018, 8'hff, `GPP_RESP_OKAY);
        analogInputSel <= 8'h0f;
        idle(3);
        chk(pullUpEn[15:8], 8'hf0, "analog pull-up");
        $display("test 4 finished");
        axw(12'h064, 8'h00, `GPP_RESP_OKAY);
        axw(12'h060, 8'hf5, `GPP_RESP_OKAY);
        idle(3);
        chk(pinOe[55:48], 8'hfa, "open-drain enable");
        chk(pinOut[55:48], 8'hf0, "open-drain drive");
        $display("test 5 finished");
        axw(`GPP_OFS_MASK, 8'h01, `GPP_RESP_OKAY);
        axw(`GPP_OFS_STATUS, 8'h01, `GPP_RESP_OKAY);
        idle(3);
        chk(irq, 0, "flag cleared");
        swVal[32] <= 1'b0;
        idle(4);
        chk(irq, 1, "falling edge irq");
        axr(`GPP_OFS_STATUS, 32'hffffffff, 32'h01, `GPP_RESP_OKAY);
        axw(`GPP_OFS_STATUS, 8'h01, `GPP_RESP_OKAY);
        idle(3);
        chk(irq, 0, "irq after clear");
        axw(`GPP_OFS_MASK, 8'h00, `GPP_RESP_OKAY);
        swVal[33] <= 1'b0;
        idle(4);
        chk(irq, 0, "masked flag");
        axr(`GPP_OFS_STATUS, 32'hffffffff, 32'h01, `GPP_RESP_OKAY);
        $display("test 6 finished");
        axw(12'h200, 8'h01, `GPP_RESP_SLVERR);
        axr(12'h200, 32'hffffffff, 32'h00, `GPP_RESP_SLVERR);
        // Lane 0 strobe off: answered, but the latch must keep its value
        s_axi_wstrb <= 4'he;
        axw(12'h020, 8'hff, `GPP_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axr(12'h020, 32'h000000a5, 32'h05, `GPP_RESP_OKAY);
        $display("test 7 finished");
        swEn[7] <= 1'b1;
        idle(2);
        axr(12'h00c, 32'h80, 32'h80, `GPP_RESP_OKAY);
        feedbackResistorCut <= 1'b0;
        idle(2);
        axr(12'h00c, 32'h80, 32'h00, `GPP_RESP_OKAY);
        $display("test 8 finished");
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        idle(2);
        chk(|{pinOe, pullUpEn, irq}, 0, "second reset");
        axr(12'h024, 32'hffffffff, 32'hff, `GPP_RESP_OKAY);
        $display("test 9 finished");
        printVerdict;
    end
endmodule // tb_general_purpose_port_pins
`default_nettype wire

/* hw/gpp_axi_slave.v */
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the top decodes addresses combinationally in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.vh"

module gpp_axi_slave (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Write address and data
    input wire [`GPP_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // Write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels
    input wire [`GPP_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Decoded access toward the register file
    output wire wrEn,
    output reg [`GPP_ADDR_W-1:0] wrAddr_q,
    output reg [31:0] wrData_q,
    output reg [3:0] wrStrb_q,
    input wire wrErr,
    output wire rdEn,
    input wire [31:0] rdData,
    input wire rdErr
);
    reg awHave_q;
    reg wHave_q;

    assign wrEn = awHave_q & wHave_q & ~s_axi_bvalid;
    assign rdEn = s_axi_arvalid & s_axi_arready;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            wrAddr_q <= {`GPP_ADDR_W{1'b0}};
            wrData_q <= 32'h00000000;
            wrStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GPP_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `GPP_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            // Ready is a registered offer so each channel takes one beat
            s_axi_awready <= ~awHave_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~wHave_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                wrAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wrData_q <= s_axi_wdata;
                wrStrb_q <= s_axi_wstrb;
            end
            if (wrEn) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrErr ? `GPP_RESP_SLVERR : `GPP_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
            end
            s_axi_arready <= ~s_axi_rvalid & ~rdEn;
            if (rdEn) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdErr ? 32'h00000000 : rdData;
                s_axi_rresp <= rdErr ? `GPP_RESP_SLVERR : `GPP_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // gpp_axi_slave

`default_nettype wire

/* hw/gpp_port.v */
// One 8-bit port: output latch, direction, pull-up select and pin drive.
// Assumes the top decodes register writes into one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.vh"

module gpp_port #(
    parameter [7:0] VALID_MASK = 8'hff,
    parameter [7:0] OD_MASK = 8'h00,
    parameter [7:0] IN_ONLY_MASK = 8'h00,
    parameter [7:0] PU_MASK = 8'hff,
    parameter BYTE_DIR = 0
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register writes
    input wire [7:0] wrData,
    input wire wrLatch,
    input wire wrMode,
    input wire wrPull,
    // Pins
    input wire [7:0] pinIn,
    input wire [7:0] pullForceOff,
    output reg [7:0] pinOut,
    output reg [7:0] pinOe,
    output reg [7:0] pullEn,
    // Register state
    output reg [7:0] latch_q,
    output reg [7:0] mode_q,
    output reg [7:0] pull_q,
    output reg [7:0] pin_q
);
    wire [7:0] mode_d;
    wire [7:0] outBits;

    // Byte-wide direction port follows bit 0 only
    assign mode_d = (BYTE_DIR != 0) ? {8{wrData[0]}} : wrData;
    assign outBits = ~mode_q & VALID_MASK & ~IN_ONLY_MASK;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= `GPP_RST_DATA;
            mode_q <= `GPP_RST_MODE;
            pull_q <= `GPP_RST_PULL;
            pin_q <= 8'h00;
            pinOut <= 8'h00;
            pinOe <= 8'h00;
            pullEn <= 8'h00;
        end else begin
            if (wrLatch) begin
                latch_q <= wrData & VALID_MASK;
            end
            if (wrMode) begin
                // Input-only and absent bits stay inputs
                mode_q <= mode_d | IN_ONLY_MASK | ~VALID_MASK;
            end
            if (wrPull) begin
                pull_q <= wrData & VALID_MASK & PU_MASK;
            end
            pin_q <= pinIn & VALID_MASK;
            // Open-drain bits only ever pull low
            pinOut <= latch_q & outBits & ~OD_MASK;
            pinOe <= outBits & (~OD_MASK | ~latch_q);
            // Pull-up only on inputs, never on analog-selected pins
            pullEn <= mode_q & pull_q & ~pullForceOff & VALID_MASK;
        end
    end
endmodule // gpp_port

`default_nettype wire

/* hw/gpp_regs.vh */
// Register map, field positions and reset values of the general-purpose port bank.
// Included by the port bank top and its helpers; holds definitions only.
`ifndef GPP_REGS_VH
`define GPP_REGS_VH

`define GPP_NPORTS 13
`define GPP_ADDR_W 12
`define GPP_PORT_STRIDE 12'h010
`define GPP_OFS_DATA 12'h000
`define GPP_OFS_MODE 12'h004
`define GPP_OFS_PULL 12'h008
`define GPP_OFS_PIN 12'h00c
`define GPP_OFS_STATUS 12'h100
`define GPP_OFS_MASK 12'h104
`define GPP_REG_SEL 3:2
`define GPP_OFS_FIELD 3:0
`define GPP_PORT_SEL 7:4

`define GPP_ST_KEYRET 0
`define GPP_ST_W 1

`define GPP_RST_DATA 8'h00
`define GPP_RST_MODE 8'hff
`define GPP_RST_PULL 8'h00
`define GPP_RST_MASK 1'b0

`define GPP_RESP_OKAY 2'b00
`define GPP_RESP_SLVERR 2'b10

`define GPP_SUBOSC_BIT 7
`define GPP_ANALOG_PORT 1
`define GPP_KEYRET_PORT 4

`endif

/* hw/gpp_top.v */
// General-purpose port bank: thirteen ports behind an AXI4-Lite register file.
// Assumes pin inputs synchronous to sys_clk and board-side pull resolution.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.vh"

module gpp_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // AXI4-Lite write address and data
    input wire [`GPP_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [`GPP_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Pins, eight lanes per port
    input wire [8*`GPP_NPORTS-1:0] pinIn,
    output wire [8*`GPP_NPORTS-1:0] pinOut,
    output wire [8*`GPP_NPORTS-1:0] pinOe,
    output wire [8*`GPP_NPORTS-1:0] pullUpEn,
    // Neighbouring blocks
    input wire [7:0] analogInputSel,
    input wire feedbackResistorCut,
    // Interrupt
    output reg irq
);
    // Lane mapping: index 0..10 is port 0..10, 11 is port 12, 12 is port 13
    function [7:0] validMask;
        input integer idx;
        begin
            case (idx)
                7: validMask = 8'h07;
                9: validMask = 8'h7f;
                10: validMask = 8'h0f;
                12: validMask = 8'h03;
                default: validMask = 8'hff;
            endcase
        end
    endfunction

    function [7:0] odMask;
        input integer idx;
        begin
            odMask = (idx == 6 || idx == 9) ? 8'h0f : 8'h00;
        end
    endfunction

    function [7:0] inOnlyMask;
        input integer idx;
        begin
            inOnlyMask = (idx == 0) ? 8'h81 : 8'h00;
        end
    endfunction

    function [7:0] puMask;
        input integer idx;
        begin
            // Sub-oscillator pin never gets a pull-up
            puMask = (idx == 0) ? 8'h7f : 8'hff;
        end
    endfunction

    wire wrEn;
    wire rdEn;
    wire [`GPP_ADDR_W-1:0] wrAddr;
    wire [31:0] wrData;
    wire [3:0] wrStrb;
    wire [8*`GPP_NPORTS-1:0] latchAll;
    wire [8*`GPP_NPORTS-1:0] modeAll;
    wire [8*`GPP_NPORTS-1:0] pullAll;
    wire [8*`GPP_NPORTS-1:0] pinAll;
    wire [3:0] wrPort;
    wire [3:0] rdPort;
    wire wrInPorts;
    wire wrByte0;
    reg [31:0] rdData;
    reg rdErr;
    reg wrErr;
    reg [7:0] pinKeyPrev_q;
    reg [`GPP_ST_W-1:0] status_q;
    reg [`GPP_ST_W-1:0] status_d;
    reg [`GPP_ST_W-1:0] mask_q;
    reg [7:0] sel;
    wire [7:0] keyFall;

    assign wrPort = wrAddr[`GPP_PORT_SEL];
    assign rdPort = s_axi_araddr[`GPP_PORT_SEL];
    assign wrInPorts = (wrAddr < `GPP_OFS_STATUS) && (wrPort < `GPP_NPORTS);
    // Every register is at most eight bits, so only lane 0 carries data
    assign wrByte0 = wrEn & wrStrb[0];

    gpp_axi_slave uBus (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn),
        .wrAddr_q(wrAddr),
        .wrData_q(wrData),
        .wrStrb_q(wrStrb),
        .wrErr(wrErr),
        .rdEn(rdEn),
        .rdData(rdData),
        .rdErr(rdErr)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `GPP_NPORTS; gi = gi + 1) begin : gPort
            wire hit;
            assign hit = wrByte0 && wrInPorts && (wrPort == gi);
            gpp_port #(
                .VALID_MASK(validMask(gi)),
                .OD_MASK(odMask(gi)),
                .IN_ONLY_MASK(inOnlyMask(gi)),
                .PU_MASK(puMask(gi)),
                .BYTE_DIR(gi == `GPP_KEYRET_PORT)
            ) uPort (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .wrData(wrData[7:0]),
                .wrLatch(hit && (wrAddr[`GPP_OFS_FIELD] == `GPP_OFS_DATA)),
                .wrMode(hit && (wrAddr[`GPP_OFS_FIELD] == `GPP_OFS_MODE)),
                .wrPull(hit && (wrAddr[`GPP_OFS_FIELD] == `GPP_OFS_PULL)),
                .pinIn(pinIn[8*gi +: 8]),
                // Analog selection overrides the software pull-up
                .pullForceOff((gi == `GPP_ANALOG_PORT) ? analogInputSel : 8'h00),
                .pinOut(pinOut[8*gi +: 8]),
                .pinOe(pinOe[8*gi +: 8]),
                .pullEn(pullUpEn[8*gi +: 8]),
                .latch_q(latchAll[8*gi +: 8]),
                .mode_q(modeAll[8*gi +: 8]),
                .pull_q(pullAll[8*gi +: 8]),
                .pin_q(pinAll[8*gi +: 8])
            );
        end
    endgenerate

    // Write decode: ports, status and mask; anything else is an error
    always @* begin
        wrErr = 1'b1;
        if (wrInPorts) begin
            wrErr = 1'b0;
        end else if (wrAddr == `GPP_OFS_STATUS || wrAddr == `GPP_OFS_MASK) begin
            wrErr = 1'b0;
        end
    end

    // Read mux; DATA shows pins on inputs and the latch on outputs
    always @* begin
        rdData = 32'h00000000;
        rdErr = 1'b0;
        sel = 8'h00;
        if (s_axi_araddr == `GPP_OFS_STATUS) begin
            rdData[`GPP_ST_W-1:0] = status_q;
        end else if (s_axi_araddr == `GPP_OFS_MASK) begin
            rdData[`GPP_ST_W-1:0] = mask_q;
        end else if (s_axi_araddr < `GPP_OFS_STATUS && rdPort < `GPP_NPORTS) begin
            sel = pinAll[8*rdPort +: 8];
            if (rdPort == 4'h0 && !feedbackResistorCut) begin
                // Oscillator still loads the pin, its level means nothing
                sel[`GPP_SUBOSC_BIT] = 1'b0;
            end
            case (s_axi_araddr[`GPP_REG_SEL])
                2'd0: rdData[7:0] = (sel & modeAll[8*rdPort +: 8])
                        | (latchAll[8*rdPort +: 8] & ~modeAll[8*rdPort +: 8]);
                2'd1: rdData[7:0] = modeAll[8*rdPort +: 8];
                2'd2: rdData[7:0] = pullAll[8*rdPort +: 8];
                default: rdData[7:0] = sel;
            endcase
        end else begin
            rdErr = 1'b1;
        end
    end

    // Edge detect on the registered pin sample of the key-return port
    assign keyFall = pinKeyPrev_q & ~pinAll[8*`GPP_KEYRET_PORT +: 8];

    always @* begin
        status_d = status_q;
        if (wrByte0 && wrAddr == `GPP_OFS_STATUS) begin
            status_d = status_q & ~wrData[`GPP_ST_W-1:0];
        end
        // Set after clear so a same-cycle edge is kept
        if (|keyFall) begin
            status_d[`GPP_ST_KEYRET] = 1'b1;
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinKeyPrev_q <= 8'h00;
            status_q <= {`GPP_ST_W{1'b0}};
            mask_q <= {`GPP_ST_W{`GPP_RST_MASK}};
            irq <= 1'b0;
        end else begin
            pinKeyPrev_q <= pinAll[8*`GPP_KEYRET_PORT +: 8];
            status_q <= status_d;
            if (wrByte0 && wrAddr == `GPP_OFS_MASK) begin
                mask_q <= wrData[`GPP_ST_W-1:0];
            end
            irq <= |(status_q & mask_q);
        end
    end
endmodule // gpp_top

`default_nettype wire
